// [hdl/rhp_port_ctrl.sv]
// Root hub downstream port status and control logic with APB register access
//
// Overview of operation
// - Writing one to bit 4 sets reset status and starts USB reset; zero does nothing.
// - Reset status reads one while reset signalling is driven, otherwise zero.
// - Writing one to bit 3 while suspended starts resume signalling.
// - Bit 3 write of one when not suspended, or of zero, is ignored.
// - No overcurrent input exists, so the overcurrent indicator always reads zero.
// - Writing one to bit 2 while connected and idle sets suspend status and suspends the port; it is ignored during reset and resume.
// - Writing one to bit 2 with nothing connected sets connect status change instead.
// - Suspend status clears itself when resume finishes or when reset signalling starts.
// - Suspend status reads one while suspended and during resume, otherwise zero.
// - Writing one to bit 1 while connected sets enable; with nothing connected it sets connect status change.
// - Completion of port reset signalling sets enable status when a device is connected.
// - Completion of resume sets enable status when a device is connected, whether or not the port was disabled.
// - Connect status in bit 0 reads one when a device is attached.
// - Nonremovable flag set makes connect status report attachment; root hub reset clears the flag.
// - Writing one to bit 0 clears port enable; zero is ignored.
module rhp_port_ctrl
  import rhp_pkg::*;
#(
  parameter int unsigned RESET_CYCLES  = RHP_RESET_CYCLES,
  parameter int unsigned RESUME_CYCLES = RHP_RESUME_CYCLES
) (
  input  wire logic        mclk_i,         // System clock, 100 MHz
  input  wire logic        rst_i,          // Synchronous reset, active high
  input  wire logic        psel_i,         // APB select
  input  wire logic        penable_i,      // APB access phase
  input  wire logic        pwrite_i,       // APB direction, high for write
  input  wire logic [11:0] paddr_i,        // APB byte address
  input  wire logic [31:0] pwdata_i,       // APB write data
  input  wire logic        dev_attached_i, // Attach detect from the port pins
  output logic      [31:0] prdata_o,       // APB read data
  output logic             pready_o,       // APB ready
  output logic             pslverr_o,      // APB error on unmapped address
  output logic             irq_o,          // Level interrupt
  output rhp_drive_t       port_drive_o    // Line signalling requests to the PHY
);

  // ----------------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------------
  localparam logic [RHP_TIMER_W-1:0] RESET_LOAD  = RHP_TIMER_W'(RESET_CYCLES - 1);
  localparam logic [RHP_TIMER_W-1:0] RESUME_LOAD = RHP_TIMER_W'(RESUME_CYCLES - 1);

  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    addr_hit = (addr[11:2] == off[11:2]);
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = addr_hit(addr, RHP_PORT_OFF) | addr_hit(addr, RHP_DESC_B_OFF) |
             addr_hit(addr, RHP_INT_STAT_OFF) | addr_hit(addr, RHP_INT_CLR_OFF) |
             addr_hit(addr, RHP_INT_EN_OFF);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rhp_state_t             state_reg;
  rhp_state_t             state_next;
  logic [RHP_TIMER_W-1:0] timer_reg;
  logic                   conn_meta_reg;
  logic                   conn_sync_reg;
  logic                   conn_prev_reg;
  logic                   boot_reg;
  logic                   enable_reg;
  logic                   csc_reg;
  logic                   nonrem_reg;
  logic [RHP_INT_W-1:0]   int_stat_reg;
  logic [RHP_INT_W-1:0]   int_en_reg;
  logic [31:0]            prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic                   irq_reg;
  rhp_drive_t             drive_reg;

  logic                   conn_now;
  logic                   conn_change;
  logic                   access;
  logic                   wr_fire;
  logic                   wr_port;
  logic                   cmd_clr_en;
  logic                   cmd_set_en;
  logic                   cmd_set_susp;
  logic                   cmd_resume;
  logic                   cmd_set_rst;
  logic                   cmd_clr_csc;
  logic                   timer_done;
  logic                   reset_done;
  logic                   resume_done;
  logic                   bad_cmd;
  logic [RHP_INT_W-1:0]   int_events;
  logic [RHP_INT_W-1:0]   int_clr;
  logic [31:0]            rd_word;

  // ----------------------------------------------------------------
  // Attach detect synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conn_meta_reg <= 1'b0;
      conn_sync_reg <= 1'b0;
    end else begin
      conn_meta_reg <= dev_attached_i;
      conn_sync_reg <= conn_meta_reg;
    end
  end

  // A nonremovable device is reported as attached from the cycle after its flag is written
  assign conn_now = conn_sync_reg | nonrem_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conn_prev_reg <= 1'b0;
      boot_reg      <= 1'b1;
    end else begin
      conn_prev_reg <= conn_now;
      boot_reg      <= 1'b0;
    end
  end

  // Boot cycle is masked so a strapped device shows one change, not two
  assign conn_change = ~boot_reg & (conn_now ^ conn_prev_reg);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: ready rises after the first access cycle, transfer ends the next
  assign access  = psel_i & penable_i;
  assign wr_fire = access & pready_reg & pwrite_i;
  assign wr_port = wr_fire & addr_hit(paddr_i, RHP_PORT_OFF) & ~pslverr_reg;

  assign cmd_clr_en   = wr_port & pwdata_i[RHP_CONN_BIT];
  assign cmd_set_en   = wr_port & pwdata_i[RHP_EN_BIT];
  assign cmd_set_susp = wr_port & pwdata_i[RHP_SUSP_BIT];
  assign cmd_resume   = wr_port & pwdata_i[RHP_OVC_BIT];
  assign cmd_set_rst  = wr_port & pwdata_i[RHP_RST_BIT];
  assign cmd_clr_csc  = wr_port & pwdata_i[RHP_CSC_BIT];

  assign int_clr = (wr_fire & addr_hit(paddr_i, RHP_INT_CLR_OFF)) ? pwdata_i[RHP_INT_W-1:0] : '0;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_hit(paddr_i, RHP_PORT_OFF)) begin
      rd_word[RHP_CONN_BIT] = conn_now;
      rd_word[RHP_EN_BIT]   = enable_reg;
      rd_word[RHP_SUSP_BIT] = (state_reg == RHP_SUSPEND) | (state_reg == RHP_RESUME);
      rd_word[RHP_OVC_BIT]  = RHP_OVC_VALUE;
      rd_word[RHP_RST_BIT]  = (state_reg == RHP_RESET);
      rd_word[RHP_CSC_BIT]  = csc_reg;
    end else if (addr_hit(paddr_i, RHP_DESC_B_OFF)) begin
      rd_word[RHP_NONREM_BIT] = nonrem_reg;
    end else if (addr_hit(paddr_i, RHP_INT_STAT_OFF)) begin
      rd_word[RHP_INT_W-1:0] = int_stat_reg;
    end else if (addr_hit(paddr_i, RHP_INT_EN_OFF)) begin
      rd_word[RHP_INT_W-1:0] = int_en_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (access & ~pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~mapped(paddr_i);
      prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_word;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Descriptor and interrupt enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nonrem_reg <= RHP_NONREM_RST;
    end else if (wr_fire & addr_hit(paddr_i, RHP_DESC_B_OFF)) begin
      nonrem_reg <= pwdata_i[RHP_NONREM_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_en_reg <= RHP_INT_RST;
    end else if (wr_fire & addr_hit(paddr_i, RHP_INT_EN_OFF)) begin
      int_en_reg <= pwdata_i[RHP_INT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------
  assign timer_done  = (timer_reg == '0);
  assign reset_done  = (state_reg == RHP_RESET) & timer_done & conn_now;
  assign resume_done = (state_reg == RHP_RESUME) & timer_done & conn_now;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RHP_IDLE: begin
        if (cmd_set_rst) begin
          state_next = RHP_RESET;
        end else if (cmd_set_susp & conn_now) begin
          state_next = RHP_SUSPEND;
        end
      end
      RHP_RESET: begin
        if (timer_done) begin
          state_next = RHP_IDLE;
        end
      end
      RHP_SUSPEND: begin
        if (cmd_set_rst) begin
          state_next = RHP_RESET;
        end else if (cmd_resume) begin
          state_next = RHP_RESUME;
        end
      end
      RHP_RESUME: begin
        if (cmd_set_rst) begin
          state_next = RHP_RESET;
        end else if (timer_done) begin
          state_next = RHP_IDLE;
        end
      end
      default: begin
        state_next = RHP_IDLE;
      end
    endcase
    // Detach drops suspend and resume; a reset request or a reset in progress still runs
    if (~conn_now & (state_next != RHP_RESET)) begin
      state_next = RHP_IDLE;
    end
    // Resume writes outside suspend fall through the case untouched
    if (state_reg != RHP_SUSPEND & cmd_resume & state_next == RHP_RESUME) begin
      state_next = state_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= RHP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timer_reg <= '0;
    end else if (state_next == RHP_RESET & state_reg != RHP_RESET) begin
      timer_reg <= RESET_LOAD;
    end else if (state_next == RHP_RESUME & state_reg != RHP_RESUME) begin
      timer_reg <= RESUME_LOAD;
    end else if (~timer_done) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Enable status
  // ----------------------------------------------------------------
  // Hardware completions win over a clear-enable write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      enable_reg <= 1'b0;
    end else if (reset_done | resume_done) begin
      enable_reg <= 1'b1;
    end else if (cmd_set_en & conn_now) begin
      enable_reg <= 1'b1;
    end else if (cmd_clr_en | ~conn_now) begin
      enable_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Connect status change flag
  // ----------------------------------------------------------------
  // Set on attach or detach, or when a reset, enable or suspend command meets an empty port
  assign bad_cmd = ~conn_now & (cmd_set_rst | cmd_set_en | cmd_set_susp);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      csc_reg <= 1'b0;
    end else if (conn_change | bad_cmd | (boot_reg & conn_now)) begin
      csc_reg <= 1'b1;
    end else if (cmd_clr_csc) begin
      csc_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign int_events[RHP_INT_CONN] = conn_change | bad_cmd | (boot_reg & conn_now);
  assign int_events[RHP_INT_RSTD] = reset_done;
  assign int_events[RHP_INT_RESD] = resume_done;

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_stat_reg <= RHP_INT_RST;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_events;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_stat_reg & int_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Line signalling requests
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      drive_reg <= '0;
    end else begin
      drive_reg.reset_drive  <= (state_next == RHP_RESET);
      drive_reg.resume_drive <= (state_next == RHP_RESUME);
      drive_reg.suspended    <= (state_next == RHP_SUSPEND);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o     = prdata_reg;
  assign pready_o     = pready_reg;
  assign pslverr_o    = pslverr_reg;
  assign irq_o        = irq_reg;
  assign port_drive_o = drive_reg;

endmodule

// [hdl/rhp_pkg.sv]
// Constants, types and register map of the root hub port status and control block
package rhp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] RHP_PORT_OFF     = 12'h000;
  localparam logic [11:0] RHP_DESC_B_OFF   = 12'h004;
  localparam logic [11:0] RHP_INT_STAT_OFF = 12'h008;
  localparam logic [11:0] RHP_INT_CLR_OFF  = 12'h00c;
  localparam logic [11:0] RHP_INT_EN_OFF   = 12'h010;

  // ----------------------------------------------------------------
  // Port and descriptor B register field positions
  // ----------------------------------------------------------------
  localparam int unsigned RHP_CONN_BIT  = 0;
  localparam int unsigned RHP_EN_BIT    = 1;
  localparam int unsigned RHP_SUSP_BIT  = 2;
  localparam int unsigned RHP_OVC_BIT   = 3;
  localparam int unsigned RHP_RST_BIT   = 4;
  localparam int unsigned RHP_CSC_BIT   = 16;
  localparam int unsigned RHP_NONREM_BIT = 1;

  // Interrupt status layout
  localparam int unsigned RHP_INT_CONN  = 0;
  localparam int unsigned RHP_INT_RSTD  = 1;
  localparam int unsigned RHP_INT_RESD  = 2;
  localparam int unsigned RHP_INT_W     = 3;

  // ----------------------------------------------------------------
  // Reset values and the fixed overcurrent read value
  // ----------------------------------------------------------------
  localparam logic                 RHP_NONREM_RST = 1'b0;
  localparam logic [RHP_INT_W-1:0] RHP_INT_RST    = 3'h0;
  localparam logic                 RHP_OVC_VALUE  = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned RHP_CLK_KHZ        = 100000;
  localparam int unsigned RHP_RESET_TIME_MS  = 10;
  localparam int unsigned RHP_RESUME_TIME_MS = 20;
  localparam int unsigned RHP_RESET_CYCLES   = RHP_RESET_TIME_MS * RHP_CLK_KHZ;
  localparam int unsigned RHP_RESUME_CYCLES  = RHP_RESUME_TIME_MS * RHP_CLK_KHZ;
  localparam int unsigned RHP_TIMER_W        = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RHP_IDLE    = 2'b00,
    RHP_RESET   = 2'b01,
    RHP_SUSPEND = 2'b11,
    RHP_RESUME  = 2'b10
  } rhp_state_t;

  typedef struct packed {
    logic reset_drive;
    logic resume_drive;
    logic suspended;
  } rhp_drive_t;

endpackage

// [tb/rhp_port_ctrl_asserts.sv]
// Concurrent checks on the root hub port block ports
module rhp_port_ctrl_chk
  import rhp_pkg::*;
#(
  parameter int unsigned RESET_CYCLES  = RHP_RESET_CYCLES,
  parameter int unsigned RESUME_CYCLES = RHP_RESUME_CYCLES
) (
  input wire logic        mclk_i,         // Clock
  input wire logic        rst_i,          // Sync reset
  input wire logic        psel_i,         // APB select
  input wire logic        penable_i,      // APB enable
  input wire logic        pwrite_i,       // APB direction
  input wire logic [11:0] paddr_i,        // APB address
  input wire logic [31:0] pwdata_i,       // APB write data
  input wire logic        dev_attached_i, // Attach pin
  input wire logic [31:0] prdata_o,       // APB read data
  input wire logic        pready_o,       // APB ready
  input wire logic        pslverr_o,      // APB error
  input wire logic        irq_o,          // Interrupt
  input wire rhp_drive_t  port_drive_o    // Line requests
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wr_port;
  int unsigned rst_cnt;
  int unsigned res_cnt;
  assign wr_port = psel_i && penable_i && pready_o && pwrite_i && (paddr_i[11:2] == 10'h000);
  // ------------------------------------------------------------
  // Length counters, cleared between pulses
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    rst_cnt <= (rst_i || !port_drive_o.reset_drive) ? 0 : rst_cnt + 1;
    res_cnt <= (rst_i || !port_drive_o.resume_drive) ? 0 : res_cnt + 1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  ready_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o) else $error("ready not after one wait");
  err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside transfer");
  ovc_zero_a: assert property (pready_o && !$past(pwrite_i) && $past(paddr_i[11:2]) == 10'h000 |-> !prdata_o[3])
    else $error("overcurrent bit set");
  reset_start_a: assert property (wr_port && pwdata_i[4] |=> port_drive_o.reset_drive)
    else $error("reset signalling not started");
  resume_start_a: assert property (wr_port && pwdata_i[3] && !pwdata_i[4] && port_drive_o.suspended
    && !port_drive_o.resume_drive && !port_drive_o.reset_drive |=> port_drive_o.resume_drive)
    else $error("resume not started");
  resume_ignore_a: assert property (wr_port && !port_drive_o.resume_drive
    && !(pwdata_i[3] && port_drive_o.suspended) |=> !port_drive_o.resume_drive) else $error("stray resume");
  reset_len_a: assert property ($fell(port_drive_o.reset_drive) |-> rst_cnt == RESET_CYCLES)
    else $error("reset signalling length wrong");
  resume_len_a: assert property ($fell(port_drive_o.resume_drive) && !port_drive_o.reset_drive
    |-> res_cnt == RESUME_CYCLES) else $error("resume length wrong");
  reset_done_c: cover property ($fell(port_drive_o.reset_drive));
  resume_done_c: cover property ($fell(port_drive_o.resume_drive));
  slverr_c: cover property (pslverr_o);
endmodule

bind rhp_port_ctrl rhp_port_ctrl_chk #(.RESET_CYCLES(RESET_CYCLES), .RESUME_CYCLES(RESUME_CYCLES)) chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .dev_attached_i(dev_attached_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .port_drive_o(port_drive_o));

// [tb/rhp_usb_dev.sv]
// Behavioural USB device standing on the port
module rhp_usb_dev
  import rhp_pkg::*;
(
  input  wire logic       mclk_i,         // Clock
  input  wire logic       rst_i,          // Sync reset
  input  wire logic       plug_i,         // Bench plugs the device in
  input  wire rhp_drive_t drive_i,        // Line requests seen on the cable
  output logic            dev_attached_o, // Presence pin
  output logic      [7:0] resets_seen_o   // USB resets received
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_rst;
  always_ff @(posedge mclk_i) begin
    dev_attached_o <= plug_i;
    prev_rst       <= rst_i ? 1'b0 : drive_i.reset_drive;
    if (rst_i) begin
      resets_seen_o <= 8'h00;
    end else if (drive_i.reset_drive && !prev_rst) begin
      resets_seen_o <= resets_seen_o + 8'h01;
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the root hub port block
module tb;
  import rhp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run brief
  localparam int RST_N = 20;
  localparam int RES_N = 30;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        plug = 1'b0;
  logic        attached;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  rhp_drive_t  drive;
  logic [7:0]  resets_seen;
  logic [31:0] rdat;
  logic        rerr;
  int          failures = 0;
  int          compares = 0;
  always #5 mclk_i = ~mclk_i;
  rhp_port_ctrl #(.RESET_CYCLES(RST_N), .RESUME_CYCLES(RES_N)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .dev_attached_i(attached), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .port_drive_o(drive));
  rhp_usb_dev dev_u (.mclk_i(mclk_i), .rst_i(rst_i), .plug_i(plug), .drive_i(drive),
    .dev_attached_o(attached), .resets_seen_o(resets_seen));
  // ------------------------------------------------------------
  // Bus tasks and reporting
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    // No fixed latency assumed; only the watchdog ends a hung wait
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(rdat & m, x);
  endtask
  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    end_of_test;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(RHP_PORT_OFF, 32'h1001f, 32'h0);
    rd(12'h020, 32'hffffffff, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    rd(RHP_INT_CLR_OFF, 32'hffffffff, 32'h0);
    wr(RHP_PORT_OFF, 32'h2);
    rd(RHP_PORT_OFF, 32'h2, 32'h0);
    wr(RHP_PORT_OFF, 32'h10000);
    wr(RHP_PORT_OFF, 32'h4);
    rd(RHP_PORT_OFF, 32'h10004, 32'h10000);
    wr(RHP_PORT_OFF, 32'h10000);
    wr(RHP_INT_CLR_OFF, 32'h7);
    wr(RHP_INT_EN_OFF, 32'h7);
    rd(RHP_INT_EN_OFF, 32'hffffffff, 32'h7);
    plug <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(RHP_INT_CLR_OFF, 32'h7);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    wr(RHP_PORT_OFF, 32'h2);
    wr(RHP_PORT_OFF, 32'h0);
    rd(RHP_PORT_OFF, 32'h3, 32'h3);
    wr(RHP_PORT_OFF, 32'h1);
    rd(RHP_PORT_OFF, 32'h3, 32'h1);
    wr(RHP_PORT_OFF, 32'h8);
    rd(RHP_PORT_OFF, 32'h1f, 32'h1);
    chk({31'h0, drive.resume_drive}, 32'h0);
    wr(RHP_PORT_OFF, 32'h10);
    rd(RHP_PORT_OFF, 32'h1f, 32'h11);
    chk({31'h0, drive.reset_drive}, 32'h1);
    repeat (RST_N + 5) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1f, 32'h3);
    chk({24'h0, resets_seen}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(RHP_INT_CLR_OFF, 32'h7);
    wr(RHP_PORT_OFF, 32'h4);
    wr(RHP_PORT_OFF, 32'h0);
    rd(RHP_PORT_OFF, 32'h1f, 32'h7);
    chk({31'h0, drive.suspended}, 32'h1);
    wr(RHP_PORT_OFF, 32'h1);
    wr(RHP_PORT_OFF, 32'h8);
    rd(RHP_PORT_OFF, 32'h4, 32'h4);
    chk({31'h0, drive.resume_drive}, 32'h1);
    repeat (RES_N + 5) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1f, 32'h3);
    wr(RHP_INT_EN_OFF, 32'h0);
    wr(RHP_PORT_OFF, 32'h4);
    wr(RHP_PORT_OFF, 32'h10);
    repeat (RST_N + 5) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1f, 32'h3);
    chk({31'h0, drive.suspended}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(RHP_INT_STAT_OFF, 32'h7, 32'h6);
    wr(RHP_PORT_OFF, 32'h4);
    wr(RHP_PORT_OFF, 32'h8);
    wr(RHP_PORT_OFF, 32'h10);
    rd(RHP_PORT_OFF, 32'h14, 32'h10);
    repeat (RST_N + 5) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1f, 32'h3);
    chk({24'h0, resets_seen}, 32'h3);
    wr(RHP_DESC_B_OFF, 32'h2);
    plug <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1, 32'h1);
    wr(RHP_DESC_B_OFF, 32'h0);
    repeat (2) @(posedge mclk_i);
    rd(RHP_PORT_OFF, 32'h1, 32'h0);
    end_of_test;
  end
endmodule
